//--- core/accel_i2c_pkg.sv
// =====================================================================
// shared constants for the two-wire accelerometer port and its controller
package accel_i2c_pkg;
  // target addresses chosen by the address select strap
  localparam logic [6:0] ADDR_STRAP_HIGH = 7'h1d;
  localparam logic [6:0] ADDR_STRAP_LOW = 7'h53;
  localparam logic RW_WRITE = 1'h0;
  localparam logic RW_READ = 1'h1;
  // bit positions inside one nine-clock byte slot
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // core clock and bus speeds, in kHz
  localparam int CORE_CLK_KHZ = 40000;
  localparam int SCL_STD_KHZ = 100;
  localparam int SCL_FAST_KHZ = 400;
  // one quarter of a bus clock period, in core cycles
  localparam int QUARTER_STD = CORE_CLK_KHZ / (4 * SCL_STD_KHZ);
  localparam int QUARTER_FAST = CORE_CLK_KHZ / (4 * SCL_FAST_KHZ);
  localparam logic [6:0] Q_STD_LOAD = 7'(QUARTER_STD - 1);
  localparam logic [6:0] Q_FAST_LOAD = 7'(QUARTER_FAST - 1);
  // write buffer shape: register pointer plus data byte
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 16;

  // decode the strap level into the 7-bit target address
  function automatic logic [6:0] target_addr(input logic strapHigh);
    return strapHigh ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;
  endfunction : target_addr
endpackage : accel_i2c_pkg

//--- core/i2c_link_if.sv
`timescale 1ns/10ps
// =====================================================================
// open-drain two-wire bus plus the mode and strap pins
interface i2c_link_if;
  logic hostSclOe;
  logic hostSclOut;
  logic hostSdaOe;
  logic hostSdaOut;
  logic devSclOe;
  logic devSclOut;
  logic devSdaOe;
  logic devSdaOut;
  logic sclLevel;
  logic sdaLevel;
  logic selectN;
  logic addressSelectStrap;

  // wired-and with pull-ups: any enabled driver with a low output pulls the line low
  assign sclLevel = !((hostSclOe && !hostSclOut) || (devSclOe && !devSclOut));
  assign sdaLevel = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

  modport dev_mp (
    input sclLevel, sdaLevel, selectN, addressSelectStrap,
    output devSclOe, devSclOut, devSdaOe, devSdaOut
  );
  modport host_mp (
    input sclLevel, sdaLevel,
    output hostSclOe, hostSclOut, hostSdaOe, hostSdaOut,
    output selectN, addressSelectStrap
  );
endinterface : i2c_link_if

//--- core/i2c_byte_fifo.sv
`timescale 1ns/10ps
// =====================================================================
// synchronous fifo with valid/ready on both sides
module i2c_byte_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW:0] next_count;
  logic [AW-1:0] next_rdPtr;

  // honest full from the fill count; the head is held in registers
  assign inReady = (count != (AW+1)'(DEPTH));
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign next_rdPtr = !pop ? rdPtr
                      : (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;

  // storage write
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wrPtr] <= inData;
  end

  // pointers and fill count
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // output register: valid and head follow the next fill state, with a
  // bypass when a word lands in an empty buffer
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      outValid <= 1'h0;
      outData <= '0;
    end
    else
    begin
      outValid <= (next_count != '0);
      outData <= (push && next_rdPtr == wrPtr) ? inData : mem[next_rdPtr];
    end
  end
endmodule : i2c_byte_fifo

//--- core/accel_i2c_target_port.sv
// Function
// - two-wire target mode while select pin high
// - works at 100 kHz and 400 kHz
// - single and multi-byte reads and writes
// - strap high answers address 0x1d
// - strap low answers address 0x53
// - select and strap pins always driven
// - sample rate kept within bus drain speed
// - unpulled pins are actively driven
// - each further byte advances register pointer
`timescale 1ns/10ps
// =====================================================================
// target end: byte engine, pointer, write buffer
module accel_i2c_target_port (
  input wire logic core_clk,
  input wire logic arst_n,
  i2c_link_if.dev_mp link,
  output logic [7:0] rdAddr,
  input wire logic [7:0] rdData,
  output logic wrValid,
  output logic [7:0] wrAddr,
  output logic [7:0] wrData,
  input wire logic wrReady,
  output logic busy
);
  typedef enum logic [2:0] {
    DEV_IDLE, DEV_RX, DEV_DECIDE, DEV_RXACK, DEV_TX, DEV_TXACK, DEV_TXNEXT
  } dev_state_t;

  dev_state_t state;
  logic sclPrev;
  logic sdaPrev;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic selected;
  logic [6:0] myAddr;
  logic [7:0] shift;
  logic [3:0] bitCnt;
  logic [7:0] ptr;
  logic isAddrByte;
  logic regPending;
  logic readMode;
  logic sdaOe;
  logic sclOe;
  logic pushValid;
  logic pushReady;
  logic [15:0] pushData;
  logic [15:0] wrWord;

  // =====================================================================
  // line edges and bus conditions
  assign selected = link.selectN;
  assign sclRise = link.sclLevel && !sclPrev;
  assign sclFall = !link.sclLevel && sclPrev;
  assign startCond = selected && sclPrev && link.sclLevel
                     && sdaPrev && !link.sdaLevel;
  assign stopCond = selected && sclPrev && link.sclLevel
                    && !sdaPrev && link.sdaLevel;

  // previous line levels for edge detection
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclPrev <= 1'h1;
      sdaPrev <= 1'h1;
    end
    else
    begin
      sclPrev <= link.sclLevel;
      sdaPrev <= link.sdaLevel;
    end
  end

  // address taken from the strap while the bus is idle
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      myAddr <= accel_i2c_pkg::ADDR_STRAP_LOW;
    else if (state == DEV_IDLE)
      myAddr <= accel_i2c_pkg::target_addr(link.addressSelectStrap);
  end

  // =====================================================================
  // byte engine: receive, acknowledge, transmit
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= DEV_IDLE;
      shift <= 8'h00;
      bitCnt <= 4'h0;
      ptr <= 8'h00;
      isAddrByte <= 1'h0;
      regPending <= 1'h0;
      readMode <= 1'h0;
      sdaOe <= 1'h0;
      sclOe <= 1'h0;
      pushValid <= 1'h0;
      pushData <= 16'h0000;
    end
    else
    begin
      pushValid <= 1'h0;
      if (!selected || stopCond)
      begin
        state <= DEV_IDLE;
        sdaOe <= 1'h0;
        sclOe <= 1'h0;
      end
      else if (startCond)
      begin
        // start or repeated start: next byte is an address byte
        state <= DEV_RX;
        bitCnt <= 4'h0;
        isAddrByte <= 1'h1;
        sdaOe <= 1'h0;
      end
      else
      begin
        case (state)
          DEV_RX:
          begin
            if (sclRise)
            begin
              shift <= {shift[6:0], link.sdaLevel};
              bitCnt <= bitCnt + 4'h1;
            end
            else if (sclFall && bitCnt == accel_i2c_pkg::BIT_ACK)
              state <= DEV_DECIDE;
          end
          DEV_DECIDE:
          begin
            if (isAddrByte)
            begin
              if (shift[7:1] == myAddr)
              begin
                readMode <= (shift[0] == accel_i2c_pkg::RW_READ);
                regPending <= (shift[0] == accel_i2c_pkg::RW_WRITE);
                isAddrByte <= 1'h0;
                sdaOe <= 1'h1;
                state <= DEV_RXACK;
              end
              else
                state <= DEV_IDLE;
            end
            else if (regPending)
            begin
              ptr <= shift;
              regPending <= 1'h0;
              sdaOe <= 1'h1;
              state <= DEV_RXACK;
            end
            else if (!pushReady)
              sclOe <= 1'h1; // stretch the clock while the buffer is full
            else
            begin
              pushValid <= 1'h1;
              pushData <= {ptr, shift};
              ptr <= ptr + 8'h01;
              sdaOe <= 1'h1;
              state <= DEV_RXACK;
            end
          end
          DEV_RXACK:
          begin
            sclOe <= 1'h0; // clock freed only after ack is on the line
            if (sclFall)
            begin
              bitCnt <= 4'h0;
              if (readMode)
              begin
                shift <= rdData;
                sdaOe <= !rdData[7];
                state <= DEV_TX;
              end
              else
              begin
                sdaOe <= 1'h0;
                state <= DEV_RX;
              end
            end
          end
          DEV_TX:
          begin
            if (sclFall)
            begin
              if (bitCnt == accel_i2c_pkg::BIT_LAST)
              begin
                sdaOe <= 1'h0;
                state <= DEV_TXACK;
              end
              else
              begin
                shift <= {shift[6:0], 1'h0};
                sdaOe <= !shift[6];
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          DEV_TXACK:
          begin
            // controller nack ends the read, ack fetches the next register
            if (sclRise)
            begin
              if (link.sdaLevel)
                state <= DEV_IDLE;
              else
              begin
                ptr <= ptr + 8'h01;
                state <= DEV_TXNEXT;
              end
            end
          end
          DEV_TXNEXT:
          begin
            if (sclFall)
            begin
              shift <= rdData;
              sdaOe <= !rdData[7];
              bitCnt <= 4'h0;
              state <= DEV_TX;
            end
          end
          default:
          begin
            sdaOe <= 1'h0;
            sclOe <= 1'h0;
          end
        endcase
      end
    end
  end

  // =====================================================================
  // user side outputs
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy <= 1'h0;
      rdAddr <= 8'h00;
    end
    else
    begin
      busy <= (state != DEV_IDLE);
      rdAddr <= ptr;
    end
  end

  // open-drain drivers only ever pull low
  assign link.devSdaOe = sdaOe;
  assign link.devSdaOut = 1'h0;
  assign link.devSclOe = sclOe;
  assign link.devSclOut = 1'h0;

  // write buffer between the bus and the register file
  i2c_byte_fifo #(
    .WIDTH(accel_i2c_pkg::FIFO_WIDTH),
    .DEPTH(accel_i2c_pkg::FIFO_DEPTH)
  ) u_i2c_byte_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(wrValid),
    .outReady(wrReady),
    .outData(wrWord)
  );
  assign wrAddr = wrWord[15:8];
  assign wrData = wrWord[7:0];
endmodule : accel_i2c_target_port

//--- core/accel_i2c_controller.sv
`timescale 1ns/10ps
// =====================================================================
// controller end: clocks the bus, frames register reads and writes
module accel_i2c_controller (
  input wire logic core_clk,
  input wire logic arst_n,
  i2c_link_if.host_mp link,
  input wire logic fastMode,
  input wire logic strapHigh,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdRead,
  input wire logic [7:0] cmdRegAddr,
  input wire logic [7:0] cmdCount,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic doneValid,
  output logic doneNack
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_LOAD, H_BYTE, H_STOP} h_state_t;
  typedef enum logic [2:0] {
    ST_ADDRW, ST_REG, ST_WDATA, ST_ADDRR, ST_RDATA
  } step_t;

  h_state_t state;
  step_t step;
  logic [6:0] tickCnt;
  logic tick;
  logic go;
  logic [1:0] phase;
  logic [3:0] bitIdx;
  logic [7:0] shift;
  logic [7:0] remain;
  logic isRead;
  logic nack;
  logic rxMode;
  logic [6:0] addr7;
  logic sclOe;
  logic sdaOe;

  // =====================================================================
  // quarter-period enable, never faster than fast speed
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      tickCnt <= accel_i2c_pkg::Q_STD_LOAD;
    else if (tickCnt == 7'h00)
      tickCnt <= fastMode ? accel_i2c_pkg::Q_FAST_LOAD
                          : accel_i2c_pkg::Q_STD_LOAD;
    else
      tickCnt <= tickCnt - 7'h01;
  end
  assign tick = (tickCnt == 7'h00);
  // phase 2 waits for the released clock line: target may stretch it
  assign go = tick && !(phase == 2'h2 && !link.sclLevel);
  assign rxMode = (step == ST_RDATA);
  assign addr7 = accel_i2c_pkg::target_addr(strapHigh);

  // =====================================================================
  // transaction sequencer
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= H_IDLE;
      step <= ST_ADDRW;
      phase <= 2'h0;
      bitIdx <= 4'h0;
      shift <= 8'h00;
      remain <= 8'h00;
      isRead <= 1'h0;
      nack <= 1'h0;
      sclOe <= 1'h0;
      sdaOe <= 1'h0;
      cmdReady <= 1'h0;
      txReady <= 1'h0;
      rxValid <= 1'h0;
      rxData <= 8'h00;
      doneValid <= 1'h0;
      doneNack <= 1'h0;
    end
    else
    begin
      txReady <= 1'h0;
      rxValid <= 1'h0;
      doneValid <= 1'h0;
      case (state)
        H_IDLE:
        begin
          cmdReady <= 1'h1;
          if (cmdValid && cmdReady)
          begin
            cmdReady <= 1'h0;
            isRead <= cmdRead;
            remain <= cmdCount;
            step <= ST_ADDRW;
            shift <= {addr7, accel_i2c_pkg::RW_WRITE};
            nack <= 1'h0;
            phase <= 2'h0;
            state <= H_START;
          end
        end
        H_START:
        begin
          if (go)
          begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: sdaOe <= 1'h0;
              2'h1: sclOe <= 1'h0;
              2'h2: sdaOe <= 1'h1;
              default:
              begin
                sclOe <= 1'h1;
                bitIdx <= 4'h0;
                state <= H_BYTE;
              end
            endcase
          end
        end
        H_LOAD:
        begin
          if (txValid)
          begin
            shift <= txData;
            txReady <= 1'h1;
            state <= H_BYTE;
          end
        end
        H_BYTE:
        begin
          if (go)
          begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0:
                if (bitIdx == accel_i2c_pkg::BIT_ACK)
                  sdaOe <= rxMode && (remain != 8'h01);
                else
                  sdaOe <= !rxMode && !shift[7];
              2'h1: sclOe <= 1'h0;
              2'h2:
                if (bitIdx == accel_i2c_pkg::BIT_ACK)
                begin
                  if (!rxMode)
                    nack <= link.sdaLevel;
                end
                else if (rxMode)
                  shift <= {shift[6:0], link.sdaLevel};
              default:
              begin
                sclOe <= 1'h1;
                if (bitIdx != accel_i2c_pkg::BIT_ACK)
                begin
                  if (!rxMode)
                    shift <= {shift[6:0], 1'h0};
                  bitIdx <= bitIdx + 4'h1;
                end
                else
                begin
                  bitIdx <= 4'h0;
                  case (step)
                    ST_ADDRW:
                      if (nack)
                        state <= H_STOP;
                      else
                      begin
                        step <= ST_REG;
                        shift <= cmdRegAddr;
                      end
                    ST_REG:
                      if (nack)
                        state <= H_STOP;
                      else if (isRead)
                      begin
                        // repeated start with the read address byte
                        step <= ST_ADDRR;
                        shift <= {addr7, accel_i2c_pkg::RW_READ};
                        state <= H_START;
                      end
                      else if (remain == 8'h00)
                        state <= H_STOP;
                      else
                      begin
                        step <= ST_WDATA;
                        state <= H_LOAD;
                      end
                    ST_WDATA:
                    begin
                      remain <= remain - 8'h01;
                      state <= (nack || remain == 8'h01) ? H_STOP : H_LOAD;
                    end
                    ST_ADDRR:
                      if (nack)
                        state <= H_STOP;
                      else
                        step <= ST_RDATA;
                    ST_RDATA:
                    begin
                      rxValid <= 1'h1;
                      rxData <= shift;
                      remain <= remain - 8'h01;
                      if (remain == 8'h01)
                        state <= H_STOP;
                    end
                    default: state <= H_STOP;
                  endcase
                end
              end
            endcase
          end
        end
        H_STOP:
        begin
          if (go)
          begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: sdaOe <= 1'h1;
              2'h1: sclOe <= 1'h0;
              2'h2: sdaOe <= 1'h0;
              default:
              begin
                doneValid <= 1'h1;
                doneNack <= nack;
                state <= H_IDLE;
              end
            endcase
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // select and strap pins held actively, never left floating
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link.selectN <= 1'h1;
      link.addressSelectStrap <= 1'h0;
    end
    else
    begin
      link.selectN <= 1'h1;
      link.addressSelectStrap <= strapHigh;
    end
  end

  assign link.hostSclOe = sclOe;
  assign link.hostSclOut = 1'h0;
  assign link.hostSdaOe = sdaOe;
  assign link.hostSdaOut = 1'h0;
endmodule : accel_i2c_controller

//--- test/i2c_link_props.sv
`timescale 1ns/10ps
// =====================================================================
// bus timing and drive checks on the shared two-wire link
module i2c_link_props (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hostSclOut,
  input wire logic hostSdaOut,
  input wire logic devSclOe,
  input wire logic devSclOut,
  input wire logic devSdaOe,
  input wire logic devSdaOut,
  input wire logic sclLevel,
  input wire logic sdaLevel,
  input wire logic selectN
);
  logic sclQ;
  logic sdaQ;
  logic [7:0] hiCnt;
  logic [7:0] perCnt;

  // line history plus saturating high-time and period counters
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclQ <= 1'h1;
      sdaQ <= 1'h1;
      hiCnt <= 8'hff;
      perCnt <= 8'hff;
    end
    else
    begin
      sclQ <= sclLevel;
      sdaQ <= sdaLevel;
      hiCnt <= !sclLevel ? 8'h00 : hiCnt + 8'(hiCnt != 8'hff);
      perCnt <= (sclLevel && !sclQ) ? 8'h01 : perCnt + 8'(perCnt != 8'hff);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_select;
    selectN;
  endproperty
  property p_open_drain;
    !hostSclOut && !hostSdaOut && !devSclOut && !devSdaOut;
  endproperty
  property p_high_time;
    (sclQ && !sclLevel) |-> hiCnt >= 8'h18;
  endproperty
  property p_period;
    (sclLevel && !sclQ) |-> perCnt >= 8'h64;
  endproperty
  property p_start_setup;
    (sclLevel && sdaQ && !sdaLevel) |-> hiCnt >= 8'h18;
  endproperty
  property p_start_hold;
    (sclLevel && sdaQ && !sdaLevel) |-> sclLevel throughout (1'b1 ##23 1'b1);
  endproperty
  property p_stop_setup;
    (sclLevel && !sdaQ && sdaLevel) |-> hiCnt >= 8'h18;
  endproperty
  property p_dev_sda;
    $changed(devSdaOe) |-> !sclLevel;
  endproperty
  property p_stretch;
    $rose(devSclOe) |-> !$past(sclLevel);
  endproperty

  a_select: assert property (p_select)
    else $error("serial select dropped low");
  a_open_drain: assert property (p_open_drain)
    else $error("a line is driven high");
  a_high_time: assert property (p_high_time)
    else $error("clock high time too short");
  a_period: assert property (p_period)
    else $error("clock period too short");
  a_start_setup: assert property (p_start_setup)
    else $error("start setup too short");
  a_start_hold: assert property (p_start_hold)
    else $error("start hold too short");
  a_stop_setup: assert property (p_stop_setup)
    else $error("stop setup too short");
  a_dev_sda: assert property (p_dev_sda)
    else $error("target moved data while clock high");
  a_stretch: assert property (p_stretch)
    else $error("stretch began while clock high");

  c_stretch: cover property ($rose(devSclOe));
  c_dev_drive: cover property ($rose(devSdaOe));
  c_stop: cover property (sclLevel && !sdaQ && sdaLevel);
endmodule : i2c_link_props

//--- test/test_accel_i2c_target_port.sv
`timescale 1ns/10ps
// =====================================================================
// controller and target joined over the link, driven from user sides
module test_accel_i2c_target_port;
  logic core_clk = 1'h0;
  logic arst_n = 1'h0;
  logic fastMode = 1'h1;
  logic strapHigh = 1'h1;
  logic cmdValid = 1'h0;
  logic cmdRead = 1'h0;
  logic [7:0] cmdRegAddr = 8'h00;
  logic [7:0] cmdCount = 8'h00;
  logic txValid = 1'h0;
  logic [7:0] txData = 8'h00;
  logic wrReady = 1'h1;
  logic cmdReady, txReady, rxValid, doneValid, doneNack, wrValid, busy;
  logic [7:0] rxData, rdAddr, rdData, wrAddr, wrData, sh;
  logic [7:0] txq[$];
  logic [7:0] rxQ[$];
  logic [7:0] addrQ[$];
  logic [15:0] popQ[$];
  logic stretchSeen = 1'h0;
  int bitN = 99;
  int fails = 0;
  int cmpCount = 0;

  i2c_link_if link();
  accel_i2c_controller u_accel_i2c_controller (.core_clk, .arst_n,
    .link(link), .fastMode, .strapHigh, .cmdValid, .cmdReady, .cmdRead,
    .cmdRegAddr, .cmdCount, .txValid, .txData, .txReady, .rxValid,
    .rxData, .doneValid, .doneNack);
  accel_i2c_target_port u_accel_i2c_target_port (.core_clk, .arst_n,
    .link(link), .rdAddr, .rdData, .wrValid, .wrAddr, .wrData, .wrReady,
    .busy);
  i2c_link_props u_i2c_link_props (.core_clk, .arst_n,
    .hostSclOut(link.hostSclOut), .hostSdaOut(link.hostSdaOut),
    .devSclOe(link.devSclOe), .devSclOut(link.devSclOut),
    .devSdaOe(link.devSdaOe), .devSdaOut(link.devSdaOut),
    .sclLevel(link.sclLevel), .sdaLevel(link.sdaLevel),
    .selectN(link.selectN));

  // register contents seen by the target
  function automatic logic [7:0] memv(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction : memv
  assign rdData = memv(rdAddr);

  always #12.5 core_clk = ~core_clk;

  // log buffer pops, received bytes and stretching
  always @(posedge core_clk)
  begin
    if (wrValid === 1'h1 && wrReady === 1'h1)
      popQ.push_back({wrAddr, wrData});
    if (rxValid === 1'h1)
      rxQ.push_back(rxData);
    if (link.devSclOe === 1'h1)
      stretchSeen = 1'h1;
  end

  // first byte after each start, msb first from the wire
  always @(negedge link.sdaLevel)
    if (link.sclLevel === 1'h1)
      bitN = 0;
  always @(posedge link.sclLevel)
  begin
    sh = {sh[6:0], link.sdaLevel};
    if (bitN == 7)
      addrQ.push_back(sh);
    bitN++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // one framed command, feeding txq and waiting for completion
  task automatic run_cmd(input logic rd, input logic [7:0] ra,
                         input logic [7:0] cnt);
    int i;
    int n;
    i = 0;
    n = 0;
    popQ.delete();
    rxQ.delete();
    addrQ.delete();
    cmdRead = rd;
    cmdRegAddr = ra;
    cmdCount = cnt;
    cmdValid = 1'h1;
    while (cmdReady !== 1'h1 && n < 200)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    #1;
    cmdValid = 1'h0;
    while (n < 60000)
    begin
      txValid = !rd && i < cnt;
      txData = (i < txq.size()) ? txq[i] : 8'h00;
      @(posedge core_clk);
      #1;
      n++;
      if (txReady === 1'h1)
        i++;
      if (doneValid === 1'h1)
        break;
    end
    check({15'h0, doneValid}, 16'h1);
    txValid = 1'h0;
    repeat (3) @(posedge core_clk);
    #1;
    check({15'h0, busy}, 16'h0);
  endtask : run_cmd

  // 17 bytes into a 16-entry buffer with the sink stalled
  task automatic t_fill();
    txq.delete();
    for (int k = 0; k < 17; k++)
      txq.push_back(8'ha0 + 8'(k));
    wrReady = 1'h0;
    stretchSeen = 1'h0;
    fork
      run_cmd(1'h0, 8'h20, 8'h11);
      begin
        for (int w = 0; w < 30000 && stretchSeen !== 1'h1; w++)
          @(posedge core_clk);
        #1;
        wrReady = 1'h1;
        check({15'h0, busy}, 16'h1);
      end
    join
    check({15'h0, stretchSeen}, 16'h1);
    check(16'(popQ.size()), 16'h11);
    for (int k = 0; k < 17; k++)
      check(popQ[k], {8'h20 + 8'(k), 8'ha0 + 8'(k)});
    check({8'h0, addrQ[0]}, 16'h3a);
    check({15'h0, doneNack}, 16'h0);
    $display("test fill done");
  endtask : t_fill

  // pointer-only write, then a three-byte read at fast speed
  task automatic t_read();
    time t0;
    txq.delete();
    run_cmd(1'h0, 8'h40, 8'h00);
    check(16'(popQ.size()), 16'h0);
    t0 = $time;
    run_cmd(1'h1, 8'h32, 8'h03);
    // a fast-speed sample read drains well inside one 800 Hz period
    check(16'($time - t0 < 1250000), 16'h1);
    for (int k = 0; k < 3; k++)
      check({8'h0, rxQ[k]}, {8'h0, memv(8'h32 + 8'(k))});
    check({addrQ[0], addrQ[1]}, 16'h3a3b);
    check({15'h0, doneNack}, 16'h0);
    $display("test read done");
  endtask : t_read

  // standard speed with the strap low, single write and read
  task automatic t_std();
    fastMode = 1'h0;
    strapHigh = 1'h0;
    repeat (4) @(posedge core_clk);
    #1;
    txq = '{8'h08};
    run_cmd(1'h0, 8'h2d, 8'h01);
    check(popQ[0], 16'h2d08);
    check({8'h0, addrQ[0]}, 16'ha6);
    run_cmd(1'h1, 8'h2d, 8'h01);
    check({8'h0, rxQ[0]}, {8'h0, memv(8'h2d)});
    check({addrQ[0], addrQ[1]}, 16'ha6a7);
    check({15'h0, doneNack}, 16'h0);
    $display("test std done");
  endtask : t_std

  // reset, then the scenarios in turn
  initial
  begin
    repeat (6) @(posedge core_clk);
    #1;
    arst_n = 1'h1;
    repeat (2) @(posedge core_clk);
    #1;
    t_fill();
    t_read();
    t_std();
    close_out();
  end

  // cut a hang short
  initial
  begin
    repeat (90000) @(posedge core_clk);
    fails++;
    $display("wrong value at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : test_accel_i2c_target_port
